/* File: src/t2c_defs.svh */
`ifndef T2C_DEFS_SVH
`define T2C_DEFS_SVH

// ****************************************
// Register addresses
// ****************************************
`define T2C_ADDR_CONTROL    8'hC8
`define T2C_ADDR_RELOAD_LO  8'hCA
`define T2C_ADDR_RELOAD_HI  8'hCB
`define T2C_ADDR_COUNT_LO   8'hCC
`define T2C_ADDR_COUNT_HI   8'hCD

// ****************************************
// Control field positions
// ****************************************
`define T2C_BIT_OVF_FLAG    7
`define T2C_BIT_EXT_FLAG    6
`define T2C_BIT_RX_CLK_SEL  5
`define T2C_BIT_TX_CLK_SEL  4
`define T2C_BIT_EXT_EN      3
`define T2C_BIT_RUN         2
`define T2C_BIT_COUNTER_SEL 1
`define T2C_BIT_CAP_RELOAD  0

// ****************************************
// Reset, count limit and unmapped read values
// ****************************************
`define T2C_RST_BYTE        8'h00
`define T2C_RST_COUNT       16'h0000
`define T2C_COUNT_MAX       16'hFFFF
`define T2C_RDATA_UNMAPPED  8'h00

// ****************************************
// Timing counts in CPU clocks per step
// ****************************************
`define T2C_DIV_SLOW        4'hC
`define T2C_DIV_FAST        4'h4
`define T2C_DIV_BAUD        4'h2

`endif

/* File: src/t2c_pkg.sv */
package t2c_pkg;

	// ****************************************
	// Special function register access
	// ****************************************
	typedef struct packed {
		logic [7:0] addr;
		logic       wr_en;
		logic       rd_en;
		logic [7:0] wdata;
	} t2c_sfr_req_t;

	// ****************************************
	// External pins and serial clocks
	// ****************************************
	typedef struct packed {
		logic count_pin;
		logic trigger_pin;
	} t2c_pins_t;

	typedef struct packed {
		logic rx_baud;
		logic tx_baud;
	} t2c_baud_t;

	typedef enum logic [1:0] {
		T2C_OFF,
		T2C_CAPTURE,
		T2C_RELOAD,
		T2C_BAUD
	} t2c_mode_t;

endpackage

/* File: src/t2c_pin_sync.sv */
`timescale 1ns/1ps
`include "t2c_defs.svh"

module t2c_pin_sync (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	// Raw pins
	input  wire t2c_pkg::t2c_pins_t pins,
	// Falling edges, bit 1 count pin, bit 0 trigger pin
	output logic      [1:0]       fall
);
	import t2c_pkg::*;

	logic [1:0] raw;
	wire  [1:0] fall_w;

	assign raw = {pins.count_pin, pins.trigger_pin};

	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_pin
			logic stage1;
			logic stage2;
			logic prev;

			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					stage1 <= 1'b1;
					stage2 <= 1'b1;
					prev   <= 1'b1;
				end else begin
					stage1 <= raw[i];
					stage2 <= stage1;
					prev   <= stage2;
				end
			end
			assign fall_w[i] = prev & ~stage2;
		end
	endgenerate

	assign fall = fall_w;

endmodule // t2c_pin_sync

/* File: src/t2c_prescale.sv */
`timescale 1ns/1ps
`include "t2c_defs.svh"

module t2c_prescale (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_n,
	// Rate selection
	input  wire logic enable,
	input  wire logic baud_mode,
	input  wire logic rate_fast,
	// Step pulse
	output logic      tick
);
	import t2c_pkg::*;

	logic [3:0] phase;
	logic [3:0] period;
	logic       wrap;

	assign period = baud_mode ? `T2C_DIV_BAUD : (rate_fast ? `T2C_DIV_FAST : `T2C_DIV_SLOW);
	assign wrap   = (phase >= period - 4'h1);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase <= 4'h0;
			tick  <= 1'b0;
		end else begin
			phase <= (!enable || wrap) ? 4'h0 : phase + 4'h1;
			tick  <= enable & wrap;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence held_baud;
		(enable && baud_mode)[*2];
	endsequence

	sequence held_fast;
		(enable && !baud_mode && rate_fast)[*4];
	endsequence

	chk_baud_rate_two: assert property (
		(tick && enable && baud_mode) ##1 held_baud |-> tick && !$past(tick))
		else $error("baud step spacing is not two clocks");

	chk_fast_rate_four: assert property (
		(tick && enable && !baud_mode && rate_fast) ##1 held_fast
		|-> tick && !$past(tick) && !$past(tick, 2) && !$past(tick, 3))
		else $error("fast step spacing is not four clocks");

endmodule // t2c_prescale

/* File: src/t2c_timer.sv */
//
// Behaviour
// - One 16-bit count in two bytes
// - Overflow sets flag unless baud selected
// - Writing one to flag requests interrupt
// - Trigger capture/reload sets external flag
// - Receive select picks this overflow as clock
// - Transmit select picks this overflow as clock
// - Trigger acts only when enabled, not baud
// - Run bit starts and stops counting
// - Counter select picks clock or pin
// - Timer steps every four or twelve clocks
// - Baud mode steps every two clocks
// - Capture copies count on trigger edge
// - Low and high bytes captured together
// - Reload on overflow and enabled trigger
// - Reload takes value from reload pair
// - Baud select forces auto-reload mode
// - Overflow output high one clock
// - Baud overflow gives shift clock, reloads
//
`timescale 1ns/1ps
`include "t2c_defs.svh"

module t2c_timer (
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst_n,
	// Register port
	input  wire t2c_pkg::t2c_sfr_req_t sfr_req,
	output logic      [7:0]            sfr_rdata,
	// External pins
	input  wire t2c_pkg::t2c_pins_t    pins,
	output logic                       overflow_output,
	// Clock rate bit from clock control register
	input  wire logic                  clock_rate_fast,
	// Serial port
	input  wire logic      [1:0]       serial_mode,
	input  wire logic                  other_timer_overflow,
	output t2c_pkg::t2c_baud_t         baud,
	// Interrupt logic
	output logic                       timer_irq_req
);
	import t2c_pkg::*;

	// ****************************************
	// State
	// ****************************************
	logic        overflow_flag;
	logic        external_flag;
	logic        receive_clock_select;
	logic        transmit_clock_select;
	logic        external_enable;
	logic        run_control;
	logic        counter_select;
	logic        capture_reload_select;
	logic [7:0]  reload_capture_low;
	logic [7:0]  reload_capture_high;
	logic [15:0] count;

	logic [7:0]  next_control;
	logic [7:0]  next_reload_low;
	logic [7:0]  next_reload_high;
	logic [15:0] next_count;
	logic [15:0] hw_count;
	logic [15:0] reload_value;

	// ****************************************
	// Register decode
	// ****************************************
	wire hit_control   = (sfr_req.addr == `T2C_ADDR_CONTROL);
	wire hit_reload_lo = (sfr_req.addr == `T2C_ADDR_RELOAD_LO);
	wire hit_reload_hi = (sfr_req.addr == `T2C_ADDR_RELOAD_HI);
	wire hit_count_lo  = (sfr_req.addr == `T2C_ADDR_COUNT_LO);
	wire hit_count_hi  = (sfr_req.addr == `T2C_ADDR_COUNT_HI);

	wire wr_control    = sfr_req.wr_en & hit_control;
	wire wr_reload_lo  = sfr_req.wr_en & hit_reload_lo;
	wire wr_reload_hi  = sfr_req.wr_en & hit_reload_hi;
	wire wr_count_lo   = sfr_req.wr_en & hit_count_lo;
	wire wr_count_hi   = sfr_req.wr_en & hit_count_hi;
	wire wr_count_any  = wr_count_lo | wr_count_hi;

	wire [7:0] control_read = {
		overflow_flag,
		external_flag,
		receive_clock_select,
		transmit_clock_select,
		external_enable,
		run_control,
		counter_select,
		capture_reload_select
	};

	wire [7:0] read_mux =
		hit_control   ? control_read        :
		hit_reload_lo ? reload_capture_low  :
		hit_reload_hi ? reload_capture_high :
		hit_count_lo  ? count[7:0]          :
		hit_count_hi  ? count[15:8]         :
		`T2C_RDATA_UNMAPPED;

	// ****************************************
	// Mode selection
	// ****************************************
	// baud select overrides capture
	wire baud_mode = receive_clock_select | transmit_clock_select;

	t2c_mode_t mode;
	assign mode = !run_control           ? T2C_OFF     :
	              baud_mode              ? T2C_BAUD    :
	              capture_reload_select  ? T2C_CAPTURE :
	                                       T2C_RELOAD;

	// ****************************************
	// Step sources
	// ****************************************
	logic       timer_tick;
	logic [1:0] pin_fall;

	t2c_prescale u_prescale (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.enable    (run_control),
		.baud_mode (baud_mode),
		.rate_fast (clock_rate_fast),
		.tick      (timer_tick)
	);

	t2c_pin_sync u_pin_sync (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.pins    (pins),
		.fall    (pin_fall)
	);

	wire count_fall   = pin_fall[1];
	wire trigger_fall = pin_fall[0];

	wire count_step = run_control & (counter_select ? count_fall : timer_tick);

	wire overflow = count_step & (count == `T2C_COUNT_MAX);

	// ****************************************
	// Trigger, capture and reload
	// ****************************************
	// trigger needs enable, no baud
	wire trigger_event = external_enable & trigger_fall & ~baud_mode;

	wire do_capture = trigger_event & capture_reload_select;

	wire reload_mode = (mode == T2C_RELOAD) | (mode == T2C_BAUD);
	wire do_reload = (overflow & reload_mode)
	               | (trigger_event & ~capture_reload_select);

	assign reload_value = {reload_capture_high, reload_capture_low};

	assign hw_count = do_reload  ? reload_value :
	                  count_step ? count + 16'h0001 :
	                               count;

	// Software byte writes win over the hardware update
	assign next_count = {
		wr_count_hi ? sfr_req.wdata : hw_count[15:8],
		wr_count_lo ? sfr_req.wdata : hw_count[7:0]
	};

	assign next_reload_low  = do_capture   ? count[7:0]    :
	                          wr_reload_lo ? sfr_req.wdata :
	                                         reload_capture_low;
	assign next_reload_high = do_capture   ? count[15:8]   :
	                          wr_reload_hi ? sfr_req.wdata :
	                                         reload_capture_high;

	// ****************************************
	// Flags and control
	// ****************************************
	// no overflow flag in baud mode
	wire overflow_set = overflow & ~baud_mode;
	wire external_set = trigger_event;

	wire [7:0] control_base = wr_control ? sfr_req.wdata : control_read;

	assign next_control = {
		overflow_set | control_base[`T2C_BIT_OVF_FLAG],
		external_set | control_base[`T2C_BIT_EXT_FLAG],
		control_base[5:0]
	};

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			{overflow_flag, external_flag, receive_clock_select, transmit_clock_select,
			 external_enable, run_control, counter_select, capture_reload_select}
				<= `T2C_RST_BYTE;
		end else begin
			{overflow_flag, external_flag, receive_clock_select, transmit_clock_select,
			 external_enable, run_control, counter_select, capture_reload_select}
				<= next_control;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reload_capture_low  <= `T2C_RST_BYTE;
			reload_capture_high <= `T2C_RST_BYTE;
			count               <= `T2C_RST_COUNT;
		end else begin
			reload_capture_low  <= next_reload_low;
			reload_capture_high <= next_reload_high;
			count               <= next_count;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// receive clock source
	wire rx_source = receive_clock_select ? overflow : other_timer_overflow;
	wire tx_source = transmit_clock_select ? overflow : other_timer_overflow;
	// Only serial modes 1 and 3 take timer clocks
	wire timer_baud_mode = serial_mode[0];

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sfr_rdata       <= `T2C_RST_BYTE;
			overflow_output <= 1'b0;
			baud            <= '0;
			timer_irq_req   <= 1'b0;
		end else begin
			sfr_rdata       <= sfr_req.rd_en ? read_mux : `T2C_RST_BYTE;
			overflow_output <= overflow;
			baud.rx_baud    <= timer_baud_mode & rx_source;
			baud.tx_baud    <= timer_baud_mode & tx_source;
			timer_irq_req   <= overflow_flag | external_flag;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	wire no_flag_write7 = !(wr_control && sfr_req.wdata[`T2C_BIT_OVF_FLAG]);
	wire no_flag_write6 = !(wr_control && sfr_req.wdata[`T2C_BIT_EXT_FLAG]);

	sequence rollover_seen;
		run_control && count_step && count == `T2C_COUNT_MAX;
	endsequence

	sequence pulse_one_clock;
		overflow_output ##1 !overflow_output;
	endsequence

	chk_ovf_pin_pulse: assert property (
		rollover_seen |=> pulse_one_clock)
		else $error("overflow output not a single clock pulse");

	chk_ovf_flag_set: assert property (
		rollover_seen ##0 !baud_mode |=> overflow_flag ##1 timer_irq_req)
		else $error("overflow flag or request missing after rollover");

	chk_baud_no_flag: assert property (
		rollover_seen ##0 baud_mode && !overflow_flag && no_flag_write7 |=> !overflow_flag)
		else $error("overflow flag set in baud mode");

	chk_reload_from_pair: assert property (
		do_reload && !wr_count_any |=> count == $past(reload_value))
		else $error("reload did not load reload pair");

	chk_capture_copy: assert property (
		do_capture && !wr_count_any |=> reload_value == $past(count))
		else $error("capture did not copy count");

	chk_run_stop_hold: assert property (
		!run_control && !do_reload && !wr_count_any |=> count == $past(count))
		else $error("count moved while stopped");

	chk_ext_flag_set: assert property (
		trigger_event |=> external_flag ##1 timer_irq_req)
		else $error("external flag not set on trigger");

	chk_ext_ignored: assert property (
		(!external_enable || baud_mode) && !external_flag && no_flag_write6
		|=> !external_flag && reload_value == $past(reload_value) || $past(wr_reload_lo)
		    || $past(wr_reload_hi))
		else $error("trigger acted while disabled");

	chk_flag_write_irq: assert property (
		wr_control && sfr_req.wdata[`T2C_BIT_OVF_FLAG] |=> overflow_flag ##1 timer_irq_req)
		else $error("written overflow flag gave no request");

	chk_rx_clock_sel: assert property (
		serial_mode[0] && !receive_clock_select && other_timer_overflow |=> baud.rx_baud)
		else $error("receive clock not from other timer");

	chk_tx_clock_sel: assert property (
		serial_mode[0] && transmit_clock_select && overflow |=> baud.tx_baud)
		else $error("transmit clock not from this overflow");

	chk_rx_clock_gate: assert property (
		!serial_mode[0] |=> !baud.rx_baud && !baud.tx_baud)
		else $error("baud pulse outside serial modes 1 and 3");

	chk_ovf_pin_quiet: assert property (
		!overflow |=> !overflow_output)
		else $error("overflow output high without rollover");

	chk_pin_step: assert property (
		run_control && counter_select && count_fall && !do_reload && !wr_count_any
		|=> count == $past(count) + 16'h0001)
		else $error("count pin edge did not step count");

	chk_pin_ignored: assert property (
		!counter_select && !timer_tick && !do_reload && !wr_count_any
		|=> count == $past(count))
		else $error("count moved without a timer step");

	chk_ovf_flag_hold: assert property (
		overflow_flag && !wr_control |=> overflow_flag)
		else $error("overflow flag cleared without write");

	chk_ext_flag_hold: assert property (
		external_flag && !wr_control |=> external_flag)
		else $error("external flag cleared without write");

endmodule // t2c_timer

/* File: testbench/t2c_far_model.sv */
`timescale 1ns/1ps

module t2c_far_model (
	// Clock
	input  wire logic             sys_clk,
	// Towards the timer
	output t2c_pkg::t2c_sfr_req_t sfr_req,
	output t2c_pkg::t2c_pins_t    pins,
	output logic                  other_timer_overflow,
	// From the timer
	input  wire logic [7:0]       sfr_rdata
);
	import t2c_pkg::*;

	initial begin
		sfr_req = '0;
		pins = 2'b11;
		other_timer_overflow = 1'b0;
	end

	// ****************************************
	// CPU register cycles
	// ****************************************
	task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
		@(negedge sys_clk);
		sfr_req = '{addr: addr, wr_en: 1'b1, rd_en: 1'b0, wdata: data};
		@(negedge sys_clk);
		sfr_req.wr_en = 1'b0;
		sfr_req.wdata = ~data;
	endtask

	task automatic sfr_read(input logic [7:0] addr, output logic [7:0] data);
		@(negedge sys_clk);
		sfr_req = '{addr: addr, wr_en: 1'b0, rd_en: 1'b1, wdata: 8'h00};
		@(negedge sys_clk);
		sfr_req.rd_en = 1'b0;
		data = sfr_rdata;
	endtask

	// ****************************************
	// Pin and serial side events
	// ****************************************
	task automatic pin_fall(input logic on_count_pin);
		@(negedge sys_clk);
		if (on_count_pin) pins.count_pin = 1'b0;
		else pins.trigger_pin = 1'b0;
		repeat (4) @(negedge sys_clk);
		pins = 2'b11;
		repeat (6) @(negedge sys_clk);
	endtask

	task automatic other_pulse();
		@(negedge sys_clk);
		other_timer_overflow = 1'b1;
		@(negedge sys_clk);
		other_timer_overflow = 1'b0;
	endtask
endmodule // t2c_far_model

/* File: testbench/t2c_timer_tb_top.sv */
`timescale 1ns/1ps

module t2c_timer_tb_top;
	import t2c_pkg::*;

	logic         sys_clk;
	logic         rst_n;
	logic         clock_rate_fast;
	logic         overflow_output;
	logic         timer_irq_req;
	logic         other_timer_overflow;
	logic [1:0]   serial_mode;
	logic [7:0]   sfr_rdata;
	logic [7:0]   rd;
	t2c_sfr_req_t sfr_req;
	t2c_pins_t    pins;
	t2c_baud_t    baud;
	int           errors;
	int           cmp_count;
	int           n;

	t2c_timer i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .sfr_req(sfr_req),
		.sfr_rdata(sfr_rdata), .pins(pins), .overflow_output(overflow_output),
		.clock_rate_fast(clock_rate_fast), .serial_mode(serial_mode),
		.other_timer_overflow(other_timer_overflow), .baud(baud),
		.timer_irq_req(timer_irq_req));

	t2c_far_model i_far (.sys_clk(sys_clk), .sfr_req(sfr_req), .pins(pins),
		.other_timer_overflow(other_timer_overflow), .sfr_rdata(sfr_rdata));

	initial sys_clk = 1'b0;
	always #2.5 sys_clk = ~sys_clk;

	// ****************************************
	// Shared helpers
	// ****************************************
	task automatic complete_run();
		$display("comparisons=%0d mismatches=%0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic check_value(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
		i_far.sfr_read(addr, rd);
		check_value(16'(rd), 16'(exp));
	endtask

	task automatic wait_ovf(output int gap);
		gap = 0;
		do begin
			@(negedge sys_clk);
			gap++;
			if (gap > 300) begin
				errors++;
				complete_run();
			end
		end while (overflow_output !== 1'b1);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic test_regs();
		logic [7:0] addr_list [6];
		addr_list = '{8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hC9};
		foreach (addr_list[i])
			rd_chk(addr_list[i], 8'h00);
		i_far.sfr_write(8'hCD, 8'hA5);
		rd_chk(8'hCD, 8'hA5);
		$display("test regs done");
	endtask

	task automatic test_rate(input logic fast, input logic [7:0] ctrl, input int exp_gap);
		clock_rate_fast = fast;
		i_far.sfr_write(8'hCB, 8'hFF);
		i_far.sfr_write(8'hCA, 8'hFE);
		i_far.sfr_write(8'hCD, 8'hFF);
		i_far.sfr_write(8'hCC, 8'hFE);
		i_far.sfr_write(8'hC8, ctrl);
		wait_ovf(n);
		wait_ovf(n);
		check_value(16'(n), 16'(exp_gap));
		check_value(16'({baud.rx_baud, baud.tx_baud}), 16'(ctrl[5:4]));
		rd_chk(8'hC8, ctrl | ((ctrl[5:4] == 2'b00) ? 8'h80 : 8'h00));
		i_far.sfr_write(8'hC8, 8'h00);
		repeat (2) @(negedge sys_clk);
		check_value(16'(timer_irq_req), 16'h0000);
		$display("test rate %h done", ctrl);
	endtask

	task automatic test_irq();
		logic [7:0] flag_list [2];
		flag_list = '{8'h80, 8'h40};
		foreach (flag_list[i]) begin
			i_far.sfr_write(8'hC8, flag_list[i]);
			repeat (2) @(negedge sys_clk);
			check_value(16'(timer_irq_req), 16'h0001);
		end
		i_far.sfr_write(8'hC8, 8'h00);
		$display("test irq done");
	endtask

	task automatic test_other();
		for (int m = 1; m >= 0; m--) begin
			serial_mode = 2'(m);
			n = 0;
			i_far.other_pulse();
			repeat (3) begin
				n += int'(baud.rx_baud) + int'(baud.tx_baud);
				@(negedge sys_clk);
			end
			check_value(16'(n), 16'(2 * m));
		end
		serial_mode = 2'b01;
		$display("test other done");
	endtask

	task automatic test_trigger();
		i_far.sfr_write(8'hCA, 8'h00);
		i_far.sfr_write(8'hC8, 8'h01);
		i_far.pin_fall(1'b0);
		rd_chk(8'hCA, 8'h00);
		rd_chk(8'hC8, 8'h01);
		i_far.sfr_write(8'hCC, 8'h34);
		i_far.sfr_write(8'hCD, 8'h12);
		i_far.sfr_write(8'hC8, 8'h09);
		i_far.pin_fall(1'b0);
		rd_chk(8'hCA, 8'h34);
		rd_chk(8'hCB, 8'h12);
		rd_chk(8'hC8, 8'h49);
		i_far.sfr_write(8'hCC, 8'h00);
		i_far.sfr_write(8'hCD, 8'h00);
		i_far.sfr_write(8'hC8, 8'h08);
		i_far.pin_fall(1'b0);
		rd_chk(8'hCC, 8'h34);
		rd_chk(8'hCD, 8'h12);
		i_far.sfr_write(8'hC8, 8'h00);
		$display("test trigger done");
	endtask

	task automatic test_counter();
		i_far.sfr_write(8'hCC, 8'h00);
		i_far.sfr_write(8'hC8, 8'h06);
		repeat (3) i_far.pin_fall(1'b1);
		i_far.sfr_write(8'hC8, 8'h02);
		i_far.pin_fall(1'b1);
		rd_chk(8'hCC, 8'h03);
		$display("test counter done");
	endtask

	initial begin
		errors = 0;
		cmp_count = 0;
		rst_n = 1'b0;
		clock_rate_fast = 1'b0;
		serial_mode = 2'b01;
		repeat (8) @(negedge sys_clk);
		rst_n = 1'b1;
		test_regs();
		test_rate(1'b0, 8'h04, 24);
		test_rate(1'b1, 8'h04, 8);
		test_rate(1'b0, 8'h34, 4);
		test_rate(1'b1, 8'h24, 4);
		test_irq();
		test_other();
		test_trigger();
		test_counter();
		complete_run();
	end
endmodule // t2c_timer_tb_top
